// file: rtl/dtd_pkg.sv
package dtd_pkg;
  // operation classes handed to the execution unit
  typedef enum logic [4:0] {
    DTD_NONE, DTD_MOVE_RM_TO_R, DTD_MOVE_R_TO_RM, DTD_MOVE_IMM_RM,
    DTD_MOVE_IMM_R, DTD_MOVE_MEM_ACC, DTD_MOVE_ACC_MEM, DTD_MOVE_TO_SEG,
    DTD_MOVE_FROM_SEG, DTD_PUSH_MEM, DTD_PUSH_REG, DTD_PUSH_SEG,
    DTD_PUSH_IMM, DTD_STACK_STORE_ALL, DTD_POP_MEM, DTD_POP_REG,
    DTD_POP_SEG, DTD_STACK_LOAD_ALL, DTD_SWAP_RM, DTD_SWAP_ACC,
    DTD_IN_FIXED, DTD_IN_VAR, DTD_OUT_FIXED, DTD_OUT_VAR,
    DTD_TABLE_TRANSLATE, DTD_LOAD_EA, DTD_LOAD_FAR_DS, DTD_LOAD_FAR_ES,
    DTD_FLAGS_TO_HIGH_ACC, DTD_HIGH_ACC_TO_FLAGS, DTD_STORE_FLAGS,
    DTD_LOAD_FLAGS
  } dtd_op_type;

  // memory operand field value meaning register operand
  localparam logic [1:0] MODE_REGISTER = 2'h3;
  // extra clocks per word memory transfer on the narrow bus
  localparam logic [7:0] WORD_PENALTY = 8'h04;
  // cycle table: index = op, two entries per bus width: reg form, mem form
  localparam int TABLE_DEPTH = 32;
  localparam int TABLE_BITS = 5;
  // star flag, one bit per op class: narrow-bus counts given for byte
  // transfers (moves to/from reg/mem and accumulator, swap rm, ports)
  localparam logic [31:0] STAR_MASK = 32'h00F4_0066;
endpackage : dtd_pkg

// file: rtl/dtd_cycle_rom.sv
`timescale 1ns/100ps
// cycle-count table, registered read; entries {w16 reg, w16 mem, w8 reg,
// w8 mem}, one byte each
module dtd_cycle_rom (
  input wire logic clk_sys,
  input wire logic [4:0] rd_addr,
  output logic [31:0] rd_data
);
  logic [31:0] rom [0:dtd_pkg::TABLE_DEPTH-1]; // constant contents

  // table is constant; kept apart so the decoder stays pure logic
  always_comb begin
    for (int i = 0; i < dtd_pkg::TABLE_DEPTH; i++) begin
      rom[i] = 32'h0000_0000;
    end
    rom[1] = 32'h0209_0209;   // reg/mem to reg
    rom[2] = 32'h020C_020C;   // reg to reg/mem
    rom[3] = 32'h0C0D_0C0D;   // immediate to reg/mem
    rom[4] = 32'h0304_0304;   // immediate to reg
    rom[5] = 32'h0808_0808;   // memory to accumulator
    rom[6] = 32'h0909_0909;   // accumulator to memory
    rom[7] = 32'h0209_020D;   // to segment
    rom[8] = 32'h020B_020F;   // from segment
    rom[9] = 32'h1010_1414;
    rom[10] = 32'h0A0A_0E0E;
    rom[11] = 32'h0909_0D0D;
    rom[12] = 32'h0A0A_0E0E;
    rom[13] = 32'h2424_4444;
    rom[14] = 32'h1414_1818;
    rom[15] = 32'h0A0A_0E0E;
    rom[16] = 32'h0808_0C0C;
    rom[17] = 32'h3333_5353;
    rom[18] = 32'h0411_0411;
    rom[19] = 32'h0303_0303;
    rom[20] = 32'h0A0A_0A0A;
    rom[21] = 32'h0808_0808;
    rom[22] = 32'h0909_0909;
    rom[23] = 32'h0707_0707;
    rom[24] = 32'h0B0B_0F0F;
    rom[25] = 32'h0606_0606;
    rom[26] = 32'h1212_1A1A;
    rom[27] = 32'h1212_1A1A;
    rom[28] = 32'h0202_0202;
    rom[29] = 32'h0303_0303;
    rom[30] = 32'h0909_0D0D;
    rom[31] = 32'h0808_0C0C;
  end

  // registered read data
  always_ff @(posedge clk_sys) begin
    rd_data <= rom[rd_addr];
  end
endmodule : dtd_cycle_rom

// file: rtl/dtd_decoder.sv
`timescale 1ns/100ps
// What this block does
// [RULE_01] 8E plus mode byte: move into segment
// [RULE_02] 8C plus mode byte: move from segment
// [RULE_03] D7 alone: table translate, 11 or 15
// [RULE_04] 8D: load effective address, 6 clocks
// [RULE_05] C5 memory only: far pointer, data segment
// [RULE_06] C4 memory only: far pointer, extra segment
// [RULE_07] 9F: flags to high accumulator, 2
// [RULE_08] 9E: high accumulator to flags, 3
// [RULE_09] narrow bus word memory transfer adds 4
// [RULE_10] low width bit: zero byte, one word
// [RULE_11] other moves, stack, swap, ports decoded with counts
module dtd_decoder (
  clk_sys,
  reset_n,
  narrow_bus,
  q_valid,
  q_byte0,
  q_byte1,
  q_ready,
  dec_valid,
  dec_op,
  dec_word,
  dec_mem,
  dec_illegal,
  dec_clocks
);
  input wire logic clk_sys; // processor clock
  input wire logic reset_n; // synchronous reset, active low
  input wire logic narrow_bus; // 1: 8-bit bus variant
  input wire logic q_valid; // queue presents opcode (and mode byte)
  input wire logic [7:0] q_byte0; // opcode byte
  input wire logic [7:0] q_byte1; // mode byte when opcode needs one
  output logic q_ready; // decoder takes the bytes
  output logic dec_valid; // result valid pulse
  output dtd_pkg::dtd_op_type dec_op; // decoded operation
  output logic dec_word; // word operand
  output logic dec_mem; // memory operand
  output logic dec_illegal; // forbidden form: unknown opcode, bad mode byte field, or register form where memory required
  output logic [7:0] dec_clocks; // minimum clock count

  dtd_pkg::dtd_op_type op_d; // combinational class
  logic word_d; // width bit
  logic mem_d; // memory form
  logic illegal_d; // forbidden form
  logic has_modrm; // opcode carries a mode byte
  logic stage_q; // rom read pending
  logic narrow_q; // bus width at take time
  logic [31:0] rom_data; // cycle table entry
  logic [7:0] base_clk; // chosen count

  // one decode per two cycles: rom read takes one extra cycle
  assign q_ready = !stage_q;

  // opcode decode: class only; width and mode byte follow from the class
  always_comb begin
    op_d = dtd_pkg::DTD_NONE;
    casez (q_byte0)
      8'b1000_101?: op_d = dtd_pkg::DTD_MOVE_RM_TO_R; // [RULE_11]
      8'b1000_100?: op_d = dtd_pkg::DTD_MOVE_R_TO_RM; // [RULE_11]
      8'b1100_011?: op_d = dtd_pkg::DTD_MOVE_IMM_RM; // [RULE_11]
      8'b1011_????: op_d = dtd_pkg::DTD_MOVE_IMM_R; // [RULE_11]
      8'b1010_000?: op_d = dtd_pkg::DTD_MOVE_MEM_ACC; // [RULE_11]
      8'b1010_001?: op_d = dtd_pkg::DTD_MOVE_ACC_MEM; // [RULE_11]
      8'b1000_1110: op_d = dtd_pkg::DTD_MOVE_TO_SEG; // [RULE_01]
      8'b1000_1100: op_d = dtd_pkg::DTD_MOVE_FROM_SEG; // [RULE_02]
      8'b1111_1111: op_d = dtd_pkg::DTD_PUSH_MEM; // [RULE_11]
      8'b0101_0???: op_d = dtd_pkg::DTD_PUSH_REG; // [RULE_11]
      8'b000?_?110: op_d = dtd_pkg::DTD_PUSH_SEG; // [RULE_11]
      8'b0110_10?0: op_d = dtd_pkg::DTD_PUSH_IMM; // [RULE_11]
      8'b0110_0000: op_d = dtd_pkg::DTD_STACK_STORE_ALL; // [RULE_11]
      8'b1000_1111: op_d = dtd_pkg::DTD_POP_MEM; // [RULE_11]
      8'b0101_1???: op_d = dtd_pkg::DTD_POP_REG; // [RULE_11]
      8'b000?_?111: begin
        // code segment cannot be popped
        if (q_byte0[4:3] != 2'h1) begin
          op_d = dtd_pkg::DTD_POP_SEG; // [RULE_11]
        end
      end
      8'b0110_0001: op_d = dtd_pkg::DTD_STACK_LOAD_ALL; // [RULE_11]
      8'b1000_011?: op_d = dtd_pkg::DTD_SWAP_RM; // [RULE_11]
      8'b1001_0???: op_d = dtd_pkg::DTD_SWAP_ACC; // [RULE_11]
      8'b1110_010?: op_d = dtd_pkg::DTD_IN_FIXED; // [RULE_11]
      8'b1110_110?: op_d = dtd_pkg::DTD_IN_VAR; // [RULE_11]
      8'b1110_011?: op_d = dtd_pkg::DTD_OUT_FIXED; // [RULE_11]
      8'b1110_111?: op_d = dtd_pkg::DTD_OUT_VAR; // [RULE_11]
      8'b1101_0111: op_d = dtd_pkg::DTD_TABLE_TRANSLATE; // [RULE_03]
      8'b1000_1101: op_d = dtd_pkg::DTD_LOAD_EA; // [RULE_04]
      8'b1100_0101: op_d = dtd_pkg::DTD_LOAD_FAR_DS; // [RULE_05]
      8'b1100_0100: op_d = dtd_pkg::DTD_LOAD_FAR_ES; // [RULE_06]
      8'b1001_1111: op_d = dtd_pkg::DTD_FLAGS_TO_HIGH_ACC; // [RULE_07]
      8'b1001_1110: op_d = dtd_pkg::DTD_HIGH_ACC_TO_FLAGS; // [RULE_08]
      8'b1001_1100: op_d = dtd_pkg::DTD_STORE_FLAGS; // [RULE_11]
      8'b1001_1101: op_d = dtd_pkg::DTD_LOAD_FLAGS; // [RULE_11]
      default: op_d = dtd_pkg::DTD_NONE;
    endcase
  end

  // width bit and mode byte presence, derived from the class
  always_comb begin
    has_modrm = 1'b0;
    word_d = 1'b1;
    case (op_d)
      // width bit in the low opcode bit, mode byte follows
      dtd_pkg::DTD_MOVE_RM_TO_R, dtd_pkg::DTD_MOVE_R_TO_RM,
      dtd_pkg::DTD_MOVE_IMM_RM, dtd_pkg::DTD_SWAP_RM: begin
        has_modrm = 1'b1;
        word_d = q_byte0[0]; // [RULE_10]
      end
      // width bit in the low opcode bit, no mode byte
      dtd_pkg::DTD_MOVE_MEM_ACC, dtd_pkg::DTD_MOVE_ACC_MEM,
      dtd_pkg::DTD_IN_FIXED, dtd_pkg::DTD_IN_VAR,
      dtd_pkg::DTD_OUT_FIXED, dtd_pkg::DTD_OUT_VAR: begin
        word_d = q_byte0[0]; // [RULE_10]
      end
      // immediate to register keeps its width bit beside the register
      dtd_pkg::DTD_MOVE_IMM_R: begin
        word_d = q_byte0[3]; // [RULE_10]
      end
      // word-only forms with a mode byte
      dtd_pkg::DTD_MOVE_TO_SEG, dtd_pkg::DTD_MOVE_FROM_SEG,
      dtd_pkg::DTD_PUSH_MEM, dtd_pkg::DTD_POP_MEM,
      dtd_pkg::DTD_LOAD_EA, dtd_pkg::DTD_LOAD_FAR_DS,
      dtd_pkg::DTD_LOAD_FAR_ES: begin
        has_modrm = 1'b1;
      end
      // byte-sized or unknown: no word transfer to charge
      dtd_pkg::DTD_NONE, dtd_pkg::DTD_TABLE_TRANSLATE,
      dtd_pkg::DTD_FLAGS_TO_HIGH_ACC,
      dtd_pkg::DTD_HIGH_ACC_TO_FLAGS: begin
        word_d = 1'b0;
      end
      // stack and accumulator swap forms move whole words
      default: begin
        word_d = 1'b1;
      end
    endcase
  end

  // memory form and illegal forms of the mode byte
  always_comb begin
    mem_d = has_modrm && (q_byte1[7:6] != dtd_pkg::MODE_REGISTER);
    illegal_d = 1'b0;
    // segment moves need a zero ahead of the register field
    if ((op_d == dtd_pkg::DTD_MOVE_TO_SEG ||
         op_d == dtd_pkg::DTD_MOVE_FROM_SEG) && q_byte1[5]) begin
      illegal_d = 1'b1; // [RULE_01] [RULE_02]
    end
    // far pointer loads need a memory operand
    if ((op_d == dtd_pkg::DTD_LOAD_FAR_DS ||
         op_d == dtd_pkg::DTD_LOAD_FAR_ES) && !mem_d) begin
      illegal_d = 1'b1; // [RULE_05] [RULE_06]
    end
    // push/pop memory need fixed sub-op field
    if (op_d == dtd_pkg::DTD_PUSH_MEM && q_byte1[5:3] != 3'h6) begin
      illegal_d = 1'b1;
    end
    if ((op_d == dtd_pkg::DTD_POP_MEM || op_d == dtd_pkg::DTD_MOVE_IMM_RM)
        && q_byte1[5:3] != 3'h0) begin
      illegal_d = 1'b1;
    end
    if (op_d == dtd_pkg::DTD_NONE) begin
      illegal_d = 1'b1;
    end
  end

  // rom address is the op class; entry read next cycle
  dtd_cycle_rom u_rom (
    .clk_sys(clk_sys),
    .rd_addr(op_d),
    .rd_data(rom_data)
  );

  // capture stage: latch decode results while rom reads
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      stage_q <= 1'b0;
      narrow_q <= 1'b0;
      dec_op <= dtd_pkg::DTD_NONE;
      dec_word <= 1'b0;
      dec_mem <= 1'b0;
      dec_illegal <= 1'b0;
    end else begin
      stage_q <= q_valid && !stage_q;
      if (q_valid && !stage_q) begin
        narrow_q <= narrow_bus;
        dec_op <= op_d;
        dec_word <= word_d;
        dec_mem <= mem_d;
        dec_illegal <= illegal_d;
      end
    end
  end

  // pick the entry for bus width and operand form
  always_comb begin
    case ({narrow_q, dec_mem})
      2'b00: base_clk = rom_data[31:24];
      2'b01: base_clk = rom_data[23:16];
      2'b10: base_clk = rom_data[15:8];
      default: base_clk = rom_data[7:0];
    endcase
  end

  // result stage; word memory transfers on the narrow bus cost extra
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      dec_valid <= 1'b0;
      dec_clocks <= 8'h00;
    end else begin
      dec_valid <= stage_q;
      if (stage_q) begin
        // accumulator and port forms always touch memory or a port
        if (narrow_q && dec_word && dtd_pkg::STAR_MASK[dec_op] &&
            (dec_mem || dec_op == dtd_pkg::DTD_MOVE_MEM_ACC ||
             dec_op == dtd_pkg::DTD_MOVE_ACC_MEM ||
             dec_op >= dtd_pkg::DTD_IN_FIXED)) begin
          dec_clocks <= base_clk + dtd_pkg::WORD_PENALTY; // [RULE_09]
        end else begin
          dec_clocks <= base_clk;
        end
      end
    end
  end

  // one clock domain: every check below samples on the processor clock
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // take of a wide-bus far pointer load with a memory operand
  sequence s_take_far_es_wide;
    q_valid && q_ready && q_byte0 == 8'hC4 &&
    q_byte1[7:6] != dtd_pkg::MODE_REGISTER && !narrow_bus;
  endsequence
  // result pulse two edges after the take
  sequence s_far_es_result;
    ##1 dec_valid && dec_clocks == 8'h12;
  endsequence

  // count at output matches narrow-bus translate figure
  chk_translate_narrow: assert property ( // [RULE_03]
    dec_valid && dec_op == dtd_pkg::DTD_TABLE_TRANSLATE && narrow_q
    |-> dec_clocks == 8'h0F) else $error("translate count wrong");
  chk_lea_count: assert property ( // [RULE_04]
    dec_valid && dec_op == dtd_pkg::DTD_LOAD_EA |-> dec_clocks == 8'h06)
    else $error("address load count wrong");
  chk_far_reg_bad: assert property ( // [RULE_05]
    q_valid && q_ready && q_byte0 == 8'hC5 && q_byte1[7:6] == 2'h3
    |=> dec_illegal) else $error("far load reg form accepted");
  chk_far_es_count: assert property ( // [RULE_06]
    s_take_far_es_wide |=> s_far_es_result) else $error("far es count");
  chk_flags_high: assert property ( // [RULE_07]
    dec_valid && dec_op == dtd_pkg::DTD_FLAGS_TO_HIGH_ACC
    |-> dec_clocks == 8'h02) else $error("flags copy count");
  chk_high_flags: assert property ( // [RULE_08]
    dec_valid && dec_op == dtd_pkg::DTD_HIGH_ACC_TO_FLAGS
    |-> dec_clocks == 8'h03) else $error("flags store count");
  chk_to_seg_mem: assert property ( // [RULE_01]
    dec_valid && dec_op == dtd_pkg::DTD_MOVE_TO_SEG && dec_mem
    |-> dec_clocks == (narrow_q ? 8'h0D : 8'h09)) else $error("seg move");
  chk_from_seg_mem: assert property ( // [RULE_02]
    dec_valid && dec_op == dtd_pkg::DTD_MOVE_FROM_SEG && dec_mem
    |-> dec_clocks == (narrow_q ? 8'h0F : 8'h0B)) else $error("seg store");
  chk_word_penalty: assert property ( // [RULE_09]
    dec_valid && dec_op == dtd_pkg::DTD_MOVE_MEM_ACC && narrow_q
    |-> dec_clocks == (dec_word ? 8'h0C : 8'h08)) else $error("penalty");
  chk_width_bit: assert property ( // [RULE_10]
    q_valid && q_ready && q_byte0[7:1] == 7'h44
    |=> dec_word == $past(q_byte0[0])) else $error("width bit");
  chk_push_reg: assert property ( // [RULE_11]
    dec_valid && dec_op == dtd_pkg::DTD_PUSH_REG
    |-> dec_clocks == (narrow_q ? 8'h0E : 8'h0A)) else $error("push count");
endmodule : dtd_decoder

// file: bench/dtd_queue_model.sv
`timescale 1ns/100ps
// prefetch queue stand-in: holds one instruction until the decoder takes it
module dtd_queue_model (
  input wire logic clk_sys,
  input wire logic reset_n, // synchronous, active low
  input wire logic load, // bench hands over a new instruction
  input wire logic [7:0] load_op, // opcode byte
  input wire logic [7:0] load_mode, // mode byte, junk for one-byte ops
  input wire logic q_ready, // decoder willing to take
  output logic q_valid, // instruction present
  output logic [7:0] q_byte0, // opcode to decoder
  output logic [7:0] q_byte1 // mode byte to decoder
);
  // present until taken, then invert the bytes so stale data never matches
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      q_valid <= 1'h0;
      q_byte0 <= 8'h00;
      q_byte1 <= 8'h00;
    end else if (load) begin
      q_valid <= 1'h1;
      q_byte0 <= load_op;
      q_byte1 <= load_mode;
    end else if (q_valid && q_ready) begin
      q_valid <= 1'h0;
      q_byte0 <= ~q_byte0;
      q_byte1 <= ~q_byte1;
    end
  end
endmodule : dtd_queue_model

// file: bench/data_transfer_decode_timing_tb.sv
`timescale 1ns/100ps
// self-checking bench for the data-transfer decoder
module data_transfer_decode_timing_tb;
  logic clk_sys; // 25 MHz processor clock
  logic reset_n; // synchronous reset, active low
  logic narrow_bus; // 1: 8-bit bus counts
  logic q_load; // hand-over strobe to queue model
  logic [7:0] q_load_op; // opcode for queue model
  logic [7:0] q_load_mode; // mode byte for queue model
  logic q_valid, q_ready, dec_valid, dec_word, dec_mem, dec_illegal;
  logic [7:0] q_byte0, q_byte1, dec_clocks;
  dtd_pkg::dtd_op_type dec_op; // decoded class
  int err_total = 0; // mismatches seen
  int checks_done = 0; // comparisons made

  dtd_queue_model u_dtd_queue_model (.clk_sys(clk_sys), .reset_n(reset_n),
    .load(q_load), .load_op(q_load_op), .load_mode(q_load_mode),
    .q_ready(q_ready), .q_valid(q_valid), .q_byte0(q_byte0),
    .q_byte1(q_byte1));
  dtd_decoder u_dtd_decoder (.clk_sys(clk_sys), .reset_n(reset_n),
    .narrow_bus(narrow_bus), .q_valid(q_valid), .q_byte0(q_byte0),
    .q_byte1(q_byte1), .q_ready(q_ready), .dec_valid(dec_valid),
    .dec_op(dec_op), .dec_word(dec_word), .dec_mem(dec_mem),
    .dec_illegal(dec_illegal), .dec_clocks(dec_clocks));

  // free-running clock, 40 ns period
  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end

  // single comparison point, four-state exact
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
    input string what);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: %s got %h want %h", $time, what, seen, exp);
    end
  endtask : check

  // one instruction through queue and decoder; exp = {illegal, mem, word};
  // mask bits: 0 word, 1 mem, 2 illegal, 3 clocks are judged
  task automatic issue(input logic [7:0] b0, input logic [7:0] b1,
    input logic nb, input dtd_pkg::dtd_op_type op, input logic [2:0] exp,
    input logic [7:0] clk_exp, input logic [3:0] mask);
    int n;
    n = 0;
    @(posedge clk_sys);
    narrow_bus <= nb;
    q_load <= 1'h1;
    q_load_op <= b0;
    q_load_mode <= b1;
    @(posedge clk_sys);
    q_load <= 1'h0;
    @(negedge clk_sys);
    // bounded wait for the take
    while (!(q_valid === 1'h1 && q_ready === 1'h1) && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 20) check(8'h00, 8'h01, "no take");
    @(negedge clk_sys);
    check({3'h0, dec_op}, {3'h0, op}, "op");
    check({7'h0, q_ready}, 8'h00, "refuse after take");
    if (mask[0]) check({7'h0, dec_word}, {7'h0, exp[0]}, "word");
    if (mask[1]) check({7'h0, dec_mem}, {7'h0, exp[1]}, "mem");
    if (mask[2]) check({7'h0, dec_illegal}, {7'h0, exp[2]}, "illegal");
    @(negedge clk_sys);
    check({7'h0, dec_valid}, 8'h01, "valid");
    if (mask[3]) check(dec_clocks, clk_exp, "clocks");
  endtask : issue

  // idle state straight after reset
  task automatic t_reset();
    check({7'h0, q_ready}, 8'h01, "ready");
    check({7'h0, dec_valid}, 8'h00, "valid idle");
    check({3'h0, dec_op}, {3'h0, dtd_pkg::DTD_NONE}, "op idle");
  endtask : t_reset

  // segment moves, both bus widths and both forms; set bit ahead of reg
  task automatic t_segment();
    issue(8'h8E, 8'h06, 1'h0, dtd_pkg::DTD_MOVE_TO_SEG,
      3'h2, 8'h09, 4'hE);
    issue(8'h8E, 8'h06, 1'h1, dtd_pkg::DTD_MOVE_TO_SEG,
      3'h2, 8'h0D, 4'hE);
    issue(8'h8E, 8'h26, 1'h0, dtd_pkg::DTD_MOVE_TO_SEG,
      3'h6, 8'h00, 4'h6);
    issue(8'h8C, 8'h06, 1'h1, dtd_pkg::DTD_MOVE_FROM_SEG,
      3'h2, 8'h0F, 4'hE);
    issue(8'h8C, 8'hC0, 1'h0, dtd_pkg::DTD_MOVE_FROM_SEG,
      3'h0, 8'h02, 4'hE);
  endtask : t_segment

  // one-byte opcodes with fixed counts
  task automatic t_single();
    issue(8'hD7, 8'h5A, 1'h0, dtd_pkg::DTD_TABLE_TRANSLATE,
      3'h0, 8'h0B, 4'hC);
    issue(8'hD7, 8'h5A, 1'h1, dtd_pkg::DTD_TABLE_TRANSLATE,
      3'h0, 8'h0F, 4'hC);
    issue(8'h9F, 8'h5A, 1'h1, dtd_pkg::DTD_FLAGS_TO_HIGH_ACC,
      3'h0, 8'h02, 4'hC);
    issue(8'h9E, 8'h5A, 1'h1, dtd_pkg::DTD_HIGH_ACC_TO_FLAGS,
      3'h0, 8'h03, 4'hC);
  endtask : t_single

  // address and far pointer loads, register form refused
  task automatic t_loads();
    issue(8'h8D, 8'h06, 1'h1, dtd_pkg::DTD_LOAD_EA,
      3'h2, 8'h06, 4'hE);
    issue(8'hC5, 8'h06, 1'h0, dtd_pkg::DTD_LOAD_FAR_DS,
      3'h2, 8'h12, 4'hE);
    issue(8'hC4, 8'h06, 1'h1, dtd_pkg::DTD_LOAD_FAR_ES,
      3'h2, 8'h1A, 4'hE);
    issue(8'hC4, 8'h06, 1'h0, dtd_pkg::DTD_LOAD_FAR_ES,
      3'h2, 8'h12, 4'hE);
    issue(8'hC5, 8'hC0, 1'h0, dtd_pkg::DTD_LOAD_FAR_DS,
      3'h4, 8'h00, 4'h4);
    issue(8'hC4, 8'hC3, 1'h1, dtd_pkg::DTD_LOAD_FAR_ES,
      3'h4, 8'h00, 4'h4);
  endtask : t_loads

  // width bit and narrow-bus word penalty on starred forms;
  // accumulator and port forms carry no mode byte, so no memory flag
  task automatic t_width();
    issue(8'h8A, 8'h06, 1'h1, dtd_pkg::DTD_MOVE_RM_TO_R,
      3'h2, 8'h09, 4'hF);
    issue(8'h8B, 8'h06, 1'h1, dtd_pkg::DTD_MOVE_RM_TO_R,
      3'h3, 8'h0D, 4'hF);
    issue(8'h8B, 8'h06, 1'h0, dtd_pkg::DTD_MOVE_RM_TO_R,
      3'h3, 8'h09, 4'hF);
    issue(8'h89, 8'hC0, 1'h1, dtd_pkg::DTD_MOVE_R_TO_RM,
      3'h1, 8'h02, 4'hF);
    issue(8'hA1, 8'h34, 1'h1, dtd_pkg::DTD_MOVE_MEM_ACC,
      3'h1, 8'h0C, 4'hF);
    issue(8'hA3, 8'h34, 1'h1, dtd_pkg::DTD_MOVE_ACC_MEM,
      3'h1, 8'h0D, 4'hF);
    issue(8'h87, 8'h06, 1'h1, dtd_pkg::DTD_SWAP_RM,
      3'h3, 8'h15, 4'hF);
    issue(8'hE5, 8'h40, 1'h1, dtd_pkg::DTD_IN_FIXED,
      3'h1, 8'h0E, 4'hF);
    issue(8'hEE, 8'h5A, 1'h1, dtd_pkg::DTD_OUT_VAR,
      3'h0, 8'h07, 4'hF);
  endtask : t_width

  // stack, swap and flag transfers plus an unknown opcode
  task automatic t_others();
    issue(8'h50, 8'h5A, 1'h0, dtd_pkg::DTD_PUSH_REG,
      3'h0, 8'h0A, 4'hC);
    issue(8'h57, 8'h5A, 1'h1, dtd_pkg::DTD_PUSH_REG,
      3'h0, 8'h0E, 4'hC);
    issue(8'h61, 8'h5A, 1'h1, dtd_pkg::DTD_STACK_LOAD_ALL,
      3'h0, 8'h53, 4'hC);
    issue(8'h93, 8'h5A, 1'h0, dtd_pkg::DTD_SWAP_ACC,
      3'h0, 8'h03, 4'hC);
    issue(8'hFF, 8'h36, 1'h1, dtd_pkg::DTD_PUSH_MEM,
      3'h0, 8'h14, 4'hC);
    issue(8'h1F, 8'h5A, 1'h1, dtd_pkg::DTD_POP_SEG,
      3'h0, 8'h0C, 4'hC);
    issue(8'h68, 8'h12, 1'h0, dtd_pkg::DTD_PUSH_IMM,
      3'h0, 8'h0A, 4'hC);
    issue(8'h9C, 8'h5A, 1'h1, dtd_pkg::DTD_STORE_FLAGS,
      3'h0, 8'h0D, 4'hC);
    issue(8'hF4, 8'h5A, 1'h0, dtd_pkg::DTD_NONE,
      3'h4, 8'h00, 4'hC);
  endtask : t_others

  // counts, verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  // main sequence: 20 cycles of reset, then every scenario
  initial begin
    reset_n = 1'h0;
    narrow_bus = 1'h0;
    q_load = 1'h0;
    q_load_op = 8'h00;
    q_load_mode = 8'h00;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'h1;
    @(negedge clk_sys);
    t_reset();
    t_segment();
    t_single();
    t_loads();
    t_width();
    t_others();
    stop_test();
  end

  // about 150 cycles needed; cut a hang well beyond that
  initial begin
    #80000;
    err_total++;
    stop_test();
  end
endmodule : data_transfer_decode_timing_tb
